// >>> shared/sanr_pkg.sv
// Purpose: Constants and carrier types for the negotiation register set
// Assumes: 16-bit management registers, 5-bit register addresses
// Notes: Frame timing values follow the standard management frame layout
package sanr_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [4:0] SANR_REG_ADVERT = 5'h04;
    localparam logic [4:0] SANR_REG_PARTNER = 5'h05;
    localparam logic [4:0] SANR_REG_EXPAND = 5'h06;
    localparam logic [4:0] SANR_REG_NP_TX = 5'h07;
    localparam logic [4:0] SANR_REG_NP_RX = 5'h08;

    // ==========================================================
    // Field positions
    localparam int SANR_BIT_LINK = 15;
    localparam int SANR_BIT_ACK = 14;
    localparam int SANR_BIT_MSG = 13;
    localparam int SANR_BIT_DUPLEX = 12;
    localparam int SANR_BIT_TOGGLE = 11;
    localparam int SANR_BIT_SPD_HI = 11;
    localparam int SANR_BIT_SPD_LO = 10;
    localparam int SANR_BIT_PAGE_RX = 1;
    localparam int SANR_BIT_NP_ABLE = 2;

    // ==========================================================
    // Reset and fixed values
    localparam logic [15:0] SANR_ADVERT_MAC = 16'h0001;
    localparam logic [15:0] SANR_PHY_FIXED = 16'h0001;
    localparam logic [15:0] SANR_PHY_WMASK = 16'hDC00;
    localparam logic [15:0] SANR_PARTNER_MASK = 16'hDC00;
    localparam logic [15:0] SANR_NPTX_WMASK = 16'hB7FF;
    localparam logic [15:0] SANR_NPTX_RST = 16'h0001;
    localparam logic [15:0] SANR_EXPAND_FIXED = 16'h0004;
    localparam logic [15:0] SANR_ZERO = 16'h0000;

    // ==========================================================
    // Frame layout
    localparam logic [1:0] SANR_OP_WRITE = 2'h1;
    localparam logic [1:0] SANR_OP_READ = 2'h2;
    localparam int SANR_PREAMBLE_MIN = 32;

    // Register bus request as seen after the serial decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] reg_addr;
        logic [15:0] data;
    } sanr_req_t;

    // Page arriving from the negotiation engine
    typedef struct packed {
        logic valid;
        logic [15:0] base;
        logic [15:0] next;
    } sanr_page_t;

endpackage : sanr_pkg

// >>> hdl/sanr_mdio_frame.sv
// Purpose: Serial management frame decoder and read-data shifter
// Assumes: mdc_en marks one rising management clock edge per pulse
// Notes: Turnaround releases the data pin; the pin is driven with oe_n low
`timescale 1ns/10ps
module sanr_mdio_frame #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mdc_en,
    input wire logic mdio_in,
    input wire logic [15:0] rd_data,
    output sanr_pkg::sanr_req_t req,
    output logic mdio_out,
    output logic mdio_oe_n
);
    import sanr_pkg::*;

    typedef enum logic [2:0] {
        SANR_IDLE, SANR_START, SANR_HEAD, SANR_TURN, SANR_DATA
    } sanr_fs_t;

    sanr_fs_t state_ff;
    logic [5:0] pre_cnt_ff;
    logic [4:0] bit_cnt_ff;
    logic [13:0] head_ff;
    logic [15:0] shift_ff;
    logic is_read_ff;
    logic mine_ff;
    logic [1:0] op;
    logic [4:0] phy;

    assign op = head_ff[11:10];
    assign phy = head_ff[9:5];

    // ==========================================================
    // Frame sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SANR_IDLE;
            pre_cnt_ff <= '0;
            bit_cnt_ff <= '0;
            head_ff <= '0;
            shift_ff <= '0;
            is_read_ff <= 1'b0;
            mine_ff <= 1'b0;
            req <= '0;
            mdio_out <= 1'b1;
            mdio_oe_n <= 1'b1;
        end else begin
            req.wr <= 1'b0;
            req.rd <= 1'b0;
            if (mdc_en) begin
                case (state_ff)
                    SANR_IDLE: begin
                        mdio_oe_n <= 1'b1;
                        if (mdio_in) begin
                            if (pre_cnt_ff < 6'(SANR_PREAMBLE_MIN))
                                pre_cnt_ff <= pre_cnt_ff + 6'h01;
                        end else if (pre_cnt_ff >= 6'(SANR_PREAMBLE_MIN)) begin
                            state_ff <= SANR_START;
                        end else begin
                            pre_cnt_ff <= '0;
                        end
                    end
                    SANR_START: begin
                        pre_cnt_ff <= '0;
                        bit_cnt_ff <= '0;
                        state_ff <= mdio_in ? SANR_HEAD : SANR_IDLE;
                    end
                    SANR_HEAD: begin
                        // Op, phy and register address: 12 bits
                        head_ff <= {head_ff[12:0], mdio_in};
                        bit_cnt_ff <= bit_cnt_ff + 5'h01;
                        if (bit_cnt_ff == 5'h0B) begin
                            state_ff <= SANR_TURN;
                            bit_cnt_ff <= '0;
                        end
                    end
                    SANR_TURN: begin
                        bit_cnt_ff <= bit_cnt_ff + 5'h01;
                        if (bit_cnt_ff == 5'h00) begin
                            is_read_ff <= (op == SANR_OP_READ);
                            mine_ff <= (phy == PHY_ADDR);
                            req.reg_addr <= head_ff[4:0];
                        end else begin
                            bit_cnt_ff <= '0;
                            state_ff <= SANR_DATA;
                            if (is_read_ff && mine_ff) begin
                                // Raised as the word is loaded, so a clear
                                // on read cannot empty a flag before it is
                                // shifted out
                                req.rd <= 1'b1;
                                mdio_oe_n <= 1'b0;
                                mdio_out <= rd_data[15];
                                shift_ff <= {rd_data[14:0], 1'b0};
                            end
                        end
                    end
                    SANR_DATA: begin
                        bit_cnt_ff <= bit_cnt_ff + 5'h01;
                        if (is_read_ff) begin
                            mdio_out <= shift_ff[15];
                            shift_ff <= {shift_ff[14:0], 1'b0};
                        end else begin
                            shift_ff <= {shift_ff[14:0], mdio_in};
                        end
                        if (bit_cnt_ff == 5'h0F) begin
                            state_ff <= SANR_IDLE;
                            mdio_oe_n <= 1'b1;
                            if (!is_read_ff && mine_ff &&
                                op == SANR_OP_WRITE) begin
                                req.wr <= 1'b1;
                                req.data <= {shift_ff[14:0], mdio_in};
                            end
                        end
                    end
                    default: state_ff <= SANR_IDLE;
                endcase
            end
        end
    end

endmodule // sanr_mdio_frame

// >>> hdl/sanr_mdc_div.sv
// Purpose: Management clock edge enable from a sampled clock pin
// Assumes: Pin inputs are synchronous to clk
// Notes: One pulse per rising edge of the sampled pin
`timescale 1ns/10ps
module sanr_mdc_div (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mdc,
    output logic mdc_en
);
    logic last_ff;

    // ==========================================================
    // Edge detect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_ff <= 1'b0;
            mdc_en <= 1'b0;
        end else begin
            last_ff <= mdc;
            mdc_en <= mdc & ~last_ff;
        end
    end

endmodule // sanr_mdc_div

// >>> hdl/sanr_regs.sv
// Purpose: Negotiation advertisement, partner, expansion and page registers
// Assumes: Management pin sampled on clk; phy_mode static during use
// Notes: Next-page logic is built only when NEXT_PAGE is set
`timescale 1ns/10ps
module sanr_regs #(
    parameter logic [4:0] PHY_ADDR = 5'h01,
    parameter bit NEXT_PAGE = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    input wire logic phy_mode,
    input wire logic cfg_valid,
    input wire logic [15:0] cfg_advert,
    input wire sanr_pkg::sanr_page_t page_in,
    input wire logic np_sent,
    output logic [15:0] advert_out,
    output logic [15:0] np_tx_out,
    output logic page_pending
);
    import sanr_pkg::*;

    if (PHY_ADDR > 5'h1F) begin : g_bad_addr
        $error("PHY_ADDR out of range");
    end

    logic mdc_en;
    sanr_req_t req;
    logic [15:0] rd_data;
    logic mdio_out_i;
    logic mdio_oe_n_i;
    logic [15:0] adv_phy_ff;
    logic [15:0] partner_ff;
    logic page_rx_ff;
    logic [15:0] np_tx_ff;
    logic [15:0] np_rx_ff;
    logic [15:0] advert_word;
    logic wr_adv;
    logic wr_np;

    // ==========================================================
    // Serial management front end
    sanr_mdc_div u_div (
        .clk(clk),
        .rst_n(rst_n),
        .mdc(mdc),
        .mdc_en(mdc_en)
    );

    sanr_mdio_frame #(.PHY_ADDR(PHY_ADDR)) u_frame (
        .clk(clk),
        .rst_n(rst_n),
        .mdc_en(mdc_en),
        .mdio_in(mdio_in),
        .rd_data(rd_data),
        .req(req),
        .mdio_out(mdio_out_i),
        .mdio_oe_n(mdio_oe_n_i)
    );

    assign mdio_out = mdio_out_i;
    assign mdio_oe_n = mdio_oe_n_i;

    assign wr_adv = req.wr && (req.reg_addr == SANR_REG_ADVERT);
    assign wr_np = req.wr && (req.reg_addr == SANR_REG_NP_TX);

    // ==========================================================
    // Advertisement word, PHY-mode writable fields
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adv_phy_ff <= SANR_ZERO;
        end else if (phy_mode) begin
            // Configuration port takes priority over a frame in flight
            if (cfg_valid)
                adv_phy_ff <= cfg_advert & SANR_PHY_WMASK;
            else if (wr_adv)
                adv_phy_ff <= req.data & SANR_PHY_WMASK;
        end
    end

    // MAC mode ignores advertisement writes entirely
    assign advert_word = phy_mode ? (adv_phy_ff | SANR_PHY_FIXED)
                                  : SANR_ADVERT_MAC;

    // ==========================================================
    // Partner ability, captured from the negotiation engine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            partner_ff <= SANR_ZERO;
        end else if (page_in.valid) begin
            partner_ff <= page_in.base & SANR_PARTNER_MASK;
        end
    end

    // ==========================================================
    // Page received flag: a new page wins over the clearing read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            page_rx_ff <= 1'b0;
        end else if (page_in.valid) begin
            page_rx_ff <= 1'b1;
        end else if (req.rd && req.reg_addr == SANR_REG_EXPAND) begin
            page_rx_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Next-page transmit word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            np_tx_ff <= SANR_NPTX_RST;
        end else if (NEXT_PAGE) begin
            if (wr_np)
                np_tx_ff <= (req.data & SANR_NPTX_WMASK) |
                    (np_tx_ff & ~SANR_NPTX_WMASK);
            if (np_sent)
                np_tx_ff[SANR_BIT_TOGGLE] <= ~np_tx_ff[SANR_BIT_TOGGLE];
        end
    end

    // ==========================================================
    // Next-page receive word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            np_rx_ff <= SANR_ZERO;
        end else if (NEXT_PAGE && page_in.valid) begin
            np_rx_ff <= page_in.next;
        end
    end

    // ==========================================================
    // Read mux; unlisted addresses read zero
    always_comb begin
        if (req.reg_addr == SANR_REG_ADVERT)
            rd_data = advert_word;
        else if (req.reg_addr == SANR_REG_PARTNER)
            rd_data = partner_ff;
        else if (req.reg_addr == SANR_REG_EXPAND)
            rd_data = SANR_EXPAND_FIXED |
                {14'h0000, page_rx_ff, 1'b0};
        else if (req.reg_addr == SANR_REG_NP_TX)
            rd_data = NEXT_PAGE ? np_tx_ff : SANR_ZERO;
        else if (req.reg_addr == SANR_REG_NP_RX)
            rd_data = NEXT_PAGE ? np_rx_ff : SANR_ZERO;
        else
            rd_data = SANR_ZERO;
    end

    // ==========================================================
    // Registered outputs toward the negotiation engine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            advert_out <= SANR_ZERO;
            np_tx_out <= SANR_ZERO;
            page_pending <= 1'b0;
        end else begin
            advert_out <= advert_word;
            np_tx_out <= NEXT_PAGE ? np_tx_ff : SANR_ZERO;
            page_pending <= page_rx_ff;
        end
    end

endmodule // sanr_regs

// >>> verification/sanr_regs_assertions.sv
// Purpose: Port-level checks of the negotiation register set
// Assumes: Single clock domain, reset active low
// Notes: Read drive length is counted in management clock rises
`timescale 1ns/10ps
module sanr_regs_assertions #(
    parameter bit NEXT_PAGE = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mdc,
    input wire logic mdio_oe_n,
    input wire logic phy_mode,
    input wire logic cfg_valid,
    input wire logic [15:0] cfg_advert,
    input wire sanr_pkg::sanr_page_t page_in,
    input wire logic [15:0] advert_out,
    input wire logic [15:0] np_tx_out,
    input wire logic page_pending
);
    import sanr_pkg::*;
    logic mdc_q_ff;
    logic [4:0] rise_cnt_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) mdc_q_ff <= 1'b0;
        else mdc_q_ff <= mdc;
    end
    // Counter clears whenever the pin is released, so each read starts at 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) rise_cnt_ff <= 5'h00;
        else if (mdio_oe_n) rise_cnt_ff <= 5'h00;
        else if (mdc && !mdc_q_ff) rise_cnt_ff <= rise_cnt_ff + 5'h01;
    end
    // ==========================================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_mac_steady;
        $past(rst_n) && !phy_mode && !$past(phy_mode) && !$past(phy_mode, 2);
    endsequence
    sequence s_phy_steady;
        $past(rst_n) && phy_mode && $past(phy_mode);
    endsequence
    sequence s_cfg_pulse;
        phy_mode && $past(phy_mode) && cfg_valid;
    endsequence
    a_mac_advert_fixed:
        assert property (s_mac_steady |-> advert_out == 16'h0001)
        else $error("advert word not fixed in mac mode");
    a_phy_reserved_bits:
        assert property (s_phy_steady |-> (advert_out & 16'h23FF) == 16'h0001)
        else $error("advert reserved bits wrong in phy mode");
    a_cfg_port_load:
        assert property (s_cfg_pulse |-> ##2
            advert_out == (($past(cfg_advert, 2) & 16'hDC00) | 16'h0001))
        else $error("config port load not seen on advert word");
    a_np_tx_zero:
        assert property (!NEXT_PAGE |-> np_tx_out == 16'h0000)
        else $error("next page word not zero");
    a_page_sets_flag:
        assert property (page_in.valid |-> ##2 page_pending)
        else $error("page flag not set after page");
    a_flag_needs_page:
        assert property ($rose(page_pending) |-> $past(page_in.valid, 2))
        else $error("page flag rose without page");
    a_read_clears_flag:
        assert property ($fell(page_pending) |-> ##[0:4] !mdio_oe_n)
        else $error("page flag cleared outside a read");
    a_read_sixteen_bits:
        assert property ($rose(mdio_oe_n) |-> rise_cnt_ff == 5'h10)
        else $error("read drive not sixteen bits long");
endmodule // sanr_regs_assertions

bind sanr_regs sanr_regs_assertions #(.NEXT_PAGE(NEXT_PAGE))
    i_sanr_regs_assertions (.clk(clk), .rst_n(rst_n), .mdc(mdc),
    .mdio_oe_n(mdio_oe_n), .phy_mode(phy_mode), .cfg_valid(cfg_valid),
    .cfg_advert(cfg_advert), .page_in(page_in), .advert_out(advert_out),
    .np_tx_out(np_tx_out), .page_pending(page_pending));

// >>> verification/sanr_mdio_station.sv
// Purpose: Management station model issuing serial frames
// Assumes: Data line has a pull-up; station owns the clock pin
// Notes: Clock pin stands low between frames
`timescale 1ns/10ps
module sanr_mdio_station (
    input wire logic clk,
    input wire logic mdio_out,
    input wire logic mdio_oe_n,
    output logic mdc,
    output logic mdio_in
);
    import sanr_pkg::*;
    logic drv;
    logic drv_en;
    initial begin
        mdc = 1'b0;
        drv = 1'b1;
        drv_en = 1'b0;
    end
    // Released line floats to the pull-up level, never the last value
    assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv : 1'b1);
    task automatic put_bit(input logic b, input logic own, output logic s);
        @(posedge clk);
        mdc <= 1'b0;
        drv <= b;
        drv_en <= own;
        repeat (2) @(posedge clk);
        s = mdio_in;
        mdc <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic frame(input logic rd, input logic [4:0] phy,
            input logic [4:0] ra, input logic [15:0] wd,
            output logic [15:0] q);
        logic [13:0] hdr;
        logic s;
        hdr = {2'b01, rd ? SANR_OP_READ : SANR_OP_WRITE, phy, ra};
        for (int i = 0; i < 32; i++) put_bit(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) put_bit(hdr[i], 1'b1, s);
        put_bit(1'b1, !rd, s);
        put_bit(1'b0, !rd, s);
        for (int i = 15; i >= 0; i--) begin
            put_bit(wd[i], !rd, s);
            q[i] = s;
        end
        @(posedge clk);
        mdc <= 1'b0;
        drv_en <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule // sanr_mdio_station

// >>> verification/sanr_regs_tb_top.sv
// Purpose: Self-checking bench for the negotiation register set
// Assumes: Next-page logic left out, station address 1
// Notes: Mode change is done under reset, as the mode is static in use
`timescale 1ns/10ps
module sanr_regs_tb_top;
    import sanr_pkg::*;
    logic clk, rst_n, phy_mode, cfg_valid, np_sent;
    logic [15:0] cfg_advert;
    sanr_page_t page_in;
    logic mdc, mdio_in, mdio_out, mdio_oe_n, page_pending;
    logic [15:0] advert_out, np_tx_out, q, d;
    int error_cnt, num_checks;
    sanr_regs i_sanr_regs (.clk(clk), .rst_n(rst_n), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
        .phy_mode(phy_mode), .cfg_valid(cfg_valid), .cfg_advert(cfg_advert),
        .page_in(page_in), .np_sent(np_sent), .advert_out(advert_out),
        .np_tx_out(np_tx_out), .page_pending(page_pending));
    sanr_mdio_station i_sanr_mdio_station (.clk(clk), .mdio_out(mdio_out),
        .mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_in(mdio_in));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ==========================================================
    // Helpers
    task chk(input string what, input logic [15:0] seen, input logic [15:0] e);
        num_checks++;
        if (seen !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, seen);
        end
    endtask
    task rd(input logic [4:0] ra);
        i_sanr_mdio_station.frame(1'b1, 5'h01, ra, 16'h0000, q);
    endtask
    task wr(input logic [4:0] ra, input logic [15:0] v);
        i_sanr_mdio_station.frame(1'b0, 5'h01, ra, v, q);
    endtask
    task cfg_pulse(input logic [15:0] v);
        @(posedge clk);
        cfg_advert <= v;
        cfg_valid <= 1'b1;
        @(posedge clk);
        cfg_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task results();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task t_defaults();
        logic [15:0] e [5];
        e = '{16'h0001, 16'h0000, 16'h0004, 16'h0000, 16'h0000};
        for (int i = 0; i < 5; i++) begin
            rd(5'h04 + 5'(i));
            chk("reset word", q, e[i]);
        end
        $display("t_defaults done");
    endtask
    task t_phy_fields();
        for (int sp = 0; sp < 4; sp++) begin
            d = {sp[1], sp[0], 1'b1, sp[1], sp[1:0], 10'h3FF};
            wr(SANR_REG_ADVERT, d);
            rd(SANR_REG_ADVERT);
            chk("advert phy", q, (d & 16'hDC00) | 16'h0001);
            chk("advert port", advert_out, (d & 16'hDC00) | 16'h0001);
        end
        $display("t_phy_fields done");
    endtask
    task t_ro_regs();
        for (int a = 5; a < 9; a++) begin
            wr(5'(a), 16'hFFFF);
            rd(5'(a));
            chk("ro word", q, (a == 6) ? 16'h0004 : 16'h0000);
        end
        chk("np port", np_tx_out, 16'h0000);
        $display("t_ro_regs done");
    endtask
    task t_cfg();
        cfg_pulse(16'h2BFF);
        chk("cfg port", advert_out, 16'h0801);
        rd(SANR_REG_ADVERT);
        chk("cfg read", q, 16'h0801);
        $display("t_cfg done");
    endtask
    task t_page();
        @(posedge clk);
        page_in <= '{1'b1, 16'hFFFF, 16'hFFFF};
        @(posedge clk);
        page_in <= '{1'b0, 16'h0000, 16'h0000};
        repeat (3) @(posedge clk);
        chk("pending set", {15'h0000, page_pending}, 16'h0001);
        rd(SANR_REG_EXPAND);
        chk("expand first", q, 16'h0006);
        rd(SANR_REG_EXPAND);
        chk("expand second", q, 16'h0004);
        chk("pending clear", {15'h0000, page_pending}, 16'h0000);
        rd(SANR_REG_PARTNER);
        chk("partner", q, 16'hDC00);
        rd(SANR_REG_NP_RX);
        chk("np rx", q, 16'h0000);
        @(posedge clk);
        np_sent <= 1'b1;
        @(posedge clk);
        np_sent <= 1'b0;
        rd(SANR_REG_NP_TX);
        chk("np tx", q, 16'h0000);
        $display("t_page done");
    endtask
    task t_other_phy();
        i_sanr_mdio_station.frame(1'b1, 5'h02, SANR_REG_ADVERT, 16'h0000, q);
        chk("foreign read", q, 16'hFFFF);
        i_sanr_mdio_station.frame(1'b0, 5'h02, SANR_REG_ADVERT, 16'h8000, q);
        rd(SANR_REG_ADVERT);
        chk("foreign write", q, 16'h0801);
        $display("t_other_phy done");
    endtask
    task t_mac();
        @(posedge clk);
        rst_n <= 1'b0;
        phy_mode <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wr(SANR_REG_ADVERT, 16'hFFFF);
        rd(SANR_REG_ADVERT);
        chk("mac read", q, 16'h0001);
        cfg_pulse(16'hFFFF);
        chk("mac port", advert_out, 16'h0001);
        $display("t_mac done");
    endtask
    initial begin
        rst_n = 1'b0;
        phy_mode = 1'b1;
        cfg_valid = 1'b0;
        cfg_advert = 16'h0000;
        page_in = '{1'b0, 16'h0000, 16'h0000};
        np_sent = 1'b0;
        error_cnt = 0;
        num_checks = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_defaults();
        t_phy_fields();
        t_ro_regs();
        t_cfg();
        t_page();
        t_other_phy();
        t_mac();
        results();
    end
    // About 32 frames of some 325 cycles each; nearly three times that is ample
    initial begin
        #3000000;
        error_cnt++;
        results();
    end
endmodule // sanr_regs_tb_top
